// File: verilog/spi_regs_pkg.sv
package spi_regs_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CAP_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h20;
  localparam logic [7:0] EVENT_OFS = 8'h24;
  localparam logic [7:0] MASK_OFS = 8'h28;
  localparam logic [7:0] CMD_OFS = 8'h2C;
  localparam logic [7:0] TX_OFS = 8'h30;
  localparam logic [7:0] RX_OFS = 8'h34;
  localparam logic [7:0] SEL_OFS = 8'h38;
  localparam logic [7:0] ASEL_OFS = 8'h3C;
  // ****************************************
  // Feature report fields
  // ****************************************
  localparam logic [7:0] SELECT_LINE_COUNT = 8'h02;
  localparam logic [3:0] MAX_WORD_SIZE_CODE = 4'h0;
  localparam logic THREE_WIRE_SUPPORT = 1'b1;
  localparam logic AUTO_MODE_FLAG = 1'b0;
  localparam logic AUTO_SELECT_AVAILABLE = 1'b1;
  localparam logic SELECT_REGISTER_PRESENT = 1'b1;
  localparam logic [7:0] FIFO_DEPTH_FIELD = 8'h10;
  localparam logic BUFFER_TYPE_FLAG = 1'b1;
  localparam logic [1:0] HARDENING_KIND = 2'h0;
  // ****************************************
  // Operating setup fields
  // ****************************************
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] MODE_WMASK = 32'h7FFF_FFFE;
  localparam int LOOP_BIT = 30;
  localparam int CPOL_BIT = 29;
  localparam int CPHA_BIT = 28;
  localparam int EXTRA_SLOW_DIVIDE_BIT = 27;
  localparam int MASTER_BIT = 25;
  localparam int ENABLE_BIT = 24;
  localparam int LEN_LSB = 20;
  localparam int PRESCALE_LSB = 16;
  localparam int AUTO_SEL_BIT = 14;
  localparam int HALVING_FLAG_BIT = 13;
  localparam int IGNORE_SEL_BIT = 2;
  // ****************************************
  // Event flag positions, select reset values and queue depth
  // ****************************************
  localparam int NOT_FULL_BIT = 8;
  localparam int NOT_EMPTY_BIT = 9;
  localparam int MULTI_MASTER_BIT = 10;
  localparam int OVERRUN_BIT = 12;
  localparam logic [1:0] SEL_RESET = 2'h3;
  localparam logic [1:0] AUTO_SEL_RESET = 2'h3;
  localparam int QUEUE_DEPTH = 16;

  typedef enum logic {ENG_IDLE, ENG_SHIFT} eng_t;
endpackage

// File: verilog/stream_if.sv
`timescale 1ns/1ns
interface stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: verilog/word_fifo.sv
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Streams
  stream_if.snk push,
  stream_if.src pop
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("word_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifo_st_t;

  fifo_st_t st;
  fifo_st_t next_st;

  function automatic logic [PW-1:0] wrap(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Full stalls the filler through ready
  assign push.ready = (st.cnt != CW'(DEPTH));
  assign pop.valid = (st.cnt != '0);
  assign pop.data = st.mem[st.rp];

  always_comb begin
    next_st = st;
    if (push.valid && push.ready) begin
      next_st.mem[st.wp] = push.data;
      next_st.wp = wrap(st.wp);
    end
    if (pop.valid && pop.ready) begin
      next_st.rp = wrap(st.rp);
    end
    case ({push.valid && push.ready, pop.valid && pop.ready})
      2'b10: next_st.cnt = CW'(st.cnt + 1'b1);
      2'b01: next_st.cnt = CW'(st.cnt - 1'b1);
      default: next_st.cnt = st.cnt;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // word_fifo

// File: verilog/spi_controller_registers.sv
`timescale 1ns/1ns
// How it works
// - All control and status sit in registers on the APB slave port.
// - Offsets 0x00, 0x20-0x28, 0x30-0x3C decode; 0x04-0x1C, 0x2C reserved.
// - Feature bits 31:24 report two select lines, read only.
// - Feature bits 23:20 read zero: word sizes 4-16 and 32.
// - Feature bit 19 reads one, though no three-wire mode is built.
// - Feature bit 18 reads zero: no automatic transfer mode.
// - Feature bit 17 reads one: automatic select driving available.
// - Feature bit 16 reads one: select register present.
// - Feature bits 15:8 report depth 16; each queue holds 17 words.
// - Feature bit 7 reads one: buffer type flag.
// - Feature bits 6:5 read zero: plain flip-flop buffers, not hardened.
// - Feature bits 4:0 carry a read-only core version.
// - Operating setup sits at 0x20 and resets to all zero.
// - Serial clock is bus clock over (4-2*halving)*(prescale+1), /16 extra.
module spi_controller_registers
  import spi_regs_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter logic [4:0] CORE_VERSION_FIELD = 5'h01 // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link
  output logic sck,
  output logic mosi,
  input wire logic miso,
  input wire logic spiSelB,
  output logic [1:0] slvSelB
);
  generate
    if (DEPTH < 2 || DEPTH > 255) begin : g_bad
      $error("DEPTH must fit the 8-bit depth field");
    end
  endgenerate

  // ****************************************
  // Feature report
  // ****************************************
  localparam logic [7:0] DEPTH_FIELD = 8'(DEPTH);
  localparam logic [31:0] FEATURES = {
    SELECT_LINE_COUNT,
    MAX_WORD_SIZE_CODE,
    THREE_WIRE_SUPPORT,
    AUTO_MODE_FLAG,
    AUTO_SELECT_AVAILABLE,
    SELECT_REGISTER_PRESENT,
    DEPTH_FIELD,
    BUFFER_TYPE_FLAG,
    HARDENING_KIND,
    CORE_VERSION_FIELD
  };

  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] mask;
    logic [1:0] sel;
    logic [1:0] autoSel;
    logic ov;
    logic mme;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] txHold;
    logic txHoldV;
    logic [31:0] rxHold;
    logic rxHoldV;
    eng_t eng;
    logic [31:0] sh;
    logic [31:0] rsh;
    logic [4:0] bitCnt;
    logic lead;
    logic [9:0] divCnt;
    logic sck;
    logic mosi;
    logic [1:0] selB;
    logic rxPush;
    logic [31:0] rxWord;
    logic [9:0] gap;
  } st_t;

  st_t st;
  st_t next_st;

  stream_if #(.WIDTH(32)) txIn ();
  stream_if #(.WIDTH(32)) txOut ();
  stream_if #(.WIDTH(32)) rxIn ();
  stream_if #(.WIDTH(32)) rxOut ();

  // ****************************************
  // Helpers
  // ****************************************
  // Half of one serial clock period, in bus clocks
  function automatic logic [9:0] halfDiv(input logic [31:0] m);
    logic [9:0] h;
    h = 10'(m[PRESCALE_LSB +: 4]) + 10'h001;
    if (!m[HALVING_FLAG_BIT]) begin
      h = 10'(h << 1);
    end
    if (m[EXTRA_SLOW_DIVIDE_BIT]) begin
      h = 10'(h << 4);
    end
    return h;
  endfunction

  // Length code zero means a 32-bit word
  function automatic logic [4:0] lastIdx(input logic [31:0] m);
    logic [3:0] len;
    len = m[LEN_LSB +: 4];
    return (len == 4'h0) ? 5'h1F : {1'b0, len};
  endfunction

  // ****************************************
  // Queues
  // ****************************************
  // Holding registers plus FIFO give depth plus one per queue
  word_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_txq (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .push(txIn.snk),
    .pop(txOut.src)
  );

  word_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_rxq (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .push(rxIn.snk),
    .pop(rxOut.src)
  );

  logic canRun;
  logic load;
  logic access;
  logic rxBit;

  assign canRun = st.mode[ENABLE_BIT] && st.mode[MASTER_BIT] && !st.mme;
  assign load = (st.eng == ENG_IDLE) && canRun && txOut.valid;
  assign access = psel && penable && !st.pready;
  assign rxBit = st.mode[LOOP_BIT] ? st.mosi : miso;

  assign txIn.valid = st.txHoldV;
  assign txIn.data = st.txHold;
  assign txOut.ready = load;
  assign rxIn.valid = st.rxPush;
  assign rxIn.data = st.rxWord;
  assign rxOut.ready = !st.rxHoldV;

  always_comb begin
    logic [31:0] rd;
    logic [31:0] ev;
    logic [31:0] r;
    logic cpha;
    rd = 32'h0000_0000;
    ev = 32'h0000_0000;
    r = st.rsh;
    cpha = st.mode[CPHA_BIT];
    next_st = st;
    next_st.rxPush = 1'b0;
    next_st.pslverr = 1'b0;

    // ****************************************
    // Queue movement
    // ****************************************
    if (st.txHoldV && txIn.ready) begin
      next_st.txHoldV = 1'b0;
    end
    if (!st.rxHoldV && rxOut.valid) begin
      next_st.rxHold = rxOut.data;
      next_st.rxHoldV = 1'b1;
    end
    if (st.rxPush && !rxIn.ready) begin
      next_st.ov = 1'b1;
    end

    // ****************************************
    // APB slave, one wait state
    // ****************************************
    next_st.pready = access;
    ev[NOT_FULL_BIT] = !st.txHoldV;
    ev[NOT_EMPTY_BIT] = st.rxHoldV;
    ev[MULTI_MASTER_BIT] = st.mme;
    ev[OVERRUN_BIT] = st.ov;
    if (access && !pwrite) begin
      case (paddr)
        CAP_OFS: rd = FEATURES;
        MODE_OFS: rd = st.mode;
        EVENT_OFS: rd = ev;
        MASK_OFS: rd = st.mask;
        RX_OFS: begin
          rd = st.rxHold;
          // An empty read must not cancel a refill already under way
          if (st.rxHoldV) begin
            next_st.rxHoldV = 1'b0;
          end
        end
        SEL_OFS: rd = {30'h0000_0000, st.sel};
        ASEL_OFS: rd = {30'h0000_0000, st.autoSel};
        default: rd = 32'h0000_0000;
      endcase
      next_st.prdata = rd;
    end
    if (access && pwrite) begin
      case (paddr)
        MODE_OFS: next_st.mode = pwdata & MODE_WMASK;
        EVENT_OFS: begin
          // Write one to clear
          if (pwdata[OVERRUN_BIT]) begin
            next_st.ov = 1'b0;
          end
          if (pwdata[MULTI_MASTER_BIT]) begin
            next_st.mme = 1'b0;
          end
        end
        MASK_OFS: next_st.mask = pwdata;
        TX_OFS: begin
          // Dropped when full; software waits for not-full
          if (!next_st.txHoldV) begin
            next_st.txHold = pwdata;
            next_st.txHoldV = 1'b1;
          end
        end
        SEL_OFS: next_st.sel = pwdata[1:0];
        ASEL_OFS: next_st.autoSel = pwdata[1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (st.rxPush && !rxIn.ready) begin
      next_st.ov = 1'b1;
    end

    // ****************************************
    // Master shift engine
    // ****************************************
    case (st.eng)
      ENG_IDLE: begin
        next_st.sck = st.mode[CPOL_BIT];
        if (load) begin
          next_st.sh = txOut.data;
          next_st.rsh = 32'h0000_0000;
          next_st.bitCnt = lastIdx(st.mode);
          next_st.lead = 1'b1;
          next_st.divCnt = 10'(halfDiv(st.mode) - 10'h001);
          next_st.eng = ENG_SHIFT;
          if (!cpha) begin
            next_st.mosi = txOut.data[lastIdx(st.mode)];
          end
        end
      end
      ENG_SHIFT: begin
        if (st.divCnt != 10'h000) begin
          next_st.divCnt = 10'(st.divCnt - 10'h001);
        end else begin
          next_st.divCnt = 10'(halfDiv(st.mode) - 10'h001);
          next_st.sck = !st.sck;
          if (st.lead) begin
            next_st.lead = 1'b0;
            if (cpha) begin
              next_st.mosi = st.sh[st.bitCnt];
            end else begin
              r = {st.rsh[30:0], rxBit};
            end
          end else begin
            next_st.lead = 1'b1;
            if (cpha) begin
              r = {st.rsh[30:0], rxBit};
            end
            if (st.bitCnt == 5'h00) begin
              next_st.rxPush = 1'b1;
              next_st.rxWord = r;
              next_st.eng = ENG_IDLE;
            end else begin
              next_st.bitCnt = 5'(st.bitCnt - 5'h01);
              if (!cpha) begin
                next_st.mosi = st.sh[5'(st.bitCnt - 5'h01)];
              end
            end
          end
          next_st.rsh = r;
        end
      end
      default: next_st.eng = ENG_IDLE;
    endcase

    // Another master selecting us aborts and disables
    if (canRun && !spiSelB && !st.mode[IGNORE_SEL_BIT]) begin
      next_st.mme = 1'b1;
      next_st.mode[ENABLE_BIT] = 1'b0;
      next_st.eng = ENG_IDLE;
      next_st.sck = st.mode[CPOL_BIT];
    end

    // Hardware selects only while a word is on the wire
    if (st.mode[AUTO_SEL_BIT] && next_st.eng == ENG_SHIFT) begin
      next_st.selB = st.autoSel;
    end else begin
      next_st.selB = next_st.sel;
    end

    if (next_st.sck != st.sck || load) begin
      next_st.gap = 10'h000;
    end else if (st.gap != 10'h3FF) begin
      next_st.gap = 10'(st.gap + 10'h001);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.mode <= MODE_RESET;
      st.sel <= SEL_RESET;
      st.autoSel <= AUTO_SEL_RESET;
      st.selB <= SEL_RESET;
      st.mosi <= 1'b1;
      st.eng <= ENG_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign sck = st.sck;
  assign mosi = st.mosi;
  assign slvSelB = st.selB;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_read(logic [7:0] ofs);
    psel && penable && !pready && !pwrite && paddr == ofs;
  endsequence

  sequence s_write(logic [7:0] ofs);
    psel && penable && !pready && pwrite && paddr == ofs;
  endsequence

  property p_readyPulse;
    @(posedge ref_clk) disable iff (!rst_b)
      pready |=> !pready;
  endproperty
  a_readyPulse: assert property (p_readyPulse)
    else $error("pready held longer than one cycle");

  property p_modeRead;
    @(posedge ref_clk) disable iff (!rst_b)
      s_read(MODE_OFS) |=> pready && prdata == $past(st.mode);
  endproperty
  a_modeRead: assert property (p_modeRead)
    else $error("setup read does not return setup");

  property p_capCount;
    @(posedge ref_clk) disable iff (!rst_b)
      s_read(CAP_OFS) |=> prdata[31:24] == 8'h02;
  endproperty
  a_capCount: assert property (p_capCount)
    else $error("select line count wrong");

  property p_capFlags;
    @(posedge ref_clk) disable iff (!rst_b)
      s_read(CAP_OFS) |=> prdata[23:16] == 8'h0B && prdata[7:5] == 3'h4;
  endproperty
  a_capFlags: assert property (p_capFlags)
    else $error("feature flags wrong");

  property p_capDepth;
    @(posedge ref_clk) disable iff (!rst_b)
      s_read(CAP_OFS) |=> prdata[15:8] == 8'h10;
  endproperty
  a_capDepth: assert property (p_capDepth)
    else $error("depth field wrong");

  property p_capVersion;
    @(posedge ref_clk) disable iff (!rst_b)
      s_read(CAP_OFS) |=> prdata[4:0] == CORE_VERSION_FIELD;
  endproperty
  a_capVersion: assert property (p_capVersion)
    else $error("core version field wrong");

  property p_modeReset;
    @(posedge ref_clk)
      $rose(rst_b) |-> st.mode == 32'h0000_0000;
  endproperty
  a_modeReset: assert property (p_modeReset)
    else $error("setup not zero after reset");

  property p_sckHalf;
    @(posedge ref_clk) disable iff (!rst_b)
      $changed(st.sck) && $past(st.eng) == ENG_SHIFT && !$rose(st.mme)
      |-> $past(st.gap) == 10'(halfDiv(st.mode) - 10'h001);
  endproperty
  a_sckHalf: assert property (p_sckHalf)
    else $error("serial clock half period wrong");

  property p_resvRead;
    @(posedge ref_clk) disable iff (!rst_b)
      (s_read(8'h04) or s_read(8'h1C) or s_read(8'h40))
      |=> prdata == 32'h0000_0000;
  endproperty
  a_resvRead: assert property (p_resvRead)
    else $error("reserved read not zero");

  property p_capWrite;
    @(posedge ref_clk) disable iff (!rst_b)
      s_write(CAP_OFS) |=> $stable(st.mode) && $stable(st.mask);
  endproperty
  a_capWrite: assert property (p_capWrite)
    else $error("feature write changed state");
endmodule // spi_controller_registers

// File: sim/spi_slave_model.sv
`timescale 1ns/1ns
module spi_slave_model #(
  parameter logic [7:0] RESP = 8'h3C
) (
  // Clock
  input wire logic ref_clk,
  // Serial link
  input wire logic sck,
  input wire logic mosi,
  input wire logic [1:0] selB,
  output logic miso,
  // Observation
  output logic [7:0] rxWord
);
  // ****************************************
  // Mode 0 slave on select line 0
  // ****************************************
  logic [7:0] outShift;
  logic idleBit;

  initial begin
    outShift = RESP;
    rxWord = 8'h00;
    idleBit = 1'b0;
  end

  // First bit must be on the line before the first clock edge
  always @(negedge selB[0]) begin
    outShift = RESP;
  end

  always @(posedge sck) begin
    if (!selB[0]) begin
      rxWord <= {rxWord[6:0], mosi};
    end
  end

  always @(negedge sck) begin
    if (!selB[0]) begin
      outShift <= {outShift[6:0], 1'b1};
    end
  end

  // Released line carries no stale level
  always @(posedge ref_clk) begin
    idleBit <= ~idleBit;
  end

  assign miso = selB[0] ? idleBit : outShift[7];
endmodule // spi_slave_model

// File: sim/tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  nChecks++; \
  if ((got) !== (exp)) begin \
    failCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module tb;
  import spi_regs_pkg::*;
  localparam logic [4:0] VER = 5'h0A; // Arbitrary value
  localparam logic [31:0] FEAT = 32'h020B_1080 | 32'(VER);
  localparam logic [31:0] CFG = 32'h4272_0000;
  localparam logic [31:0] NOLOOP = 32'h0272_0000;
  localparam logic [31:0] EN = 32'h0100_0000;
  localparam int HALF = 6;
  // Loop, idle high, late phase, slow divide, halving, auto select, 32 bits
  localparam logic [31:0] ALT = 32'h7A00_6000;
  logic refClk = 1'b0;
  logic rstB = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic spiSelB = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sck;
  logic mosi;
  logic miso;
  logic [1:0] slvSelB;
  logic [7:0] slvRx;
  logic [31:0] rd;
  int failCount = 0;
  int nChecks = 0;
  int cycles = 0;

  always #10 refClk = ~refClk;

  spi_controller_registers #(.CORE_VERSION_FIELD(VER))
    spi_controller_registers_inst (
    .ref_clk(refClk), .rst_b(rstB), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck(sck), .mosi(mosi),
    .miso(miso), .spiSelB(spiSelB), .slvSelB(slvSelB));

  spi_slave_model spi_slave_model_inst (
    .ref_clk(refClk), .sck(sck), .mosi(mosi), .selB(slvSelB),
    .miso(miso), .rxWord(slvRx));

  // ****************************************
  // Bus access and helpers
  // ****************************************
  task automatic apb(input logic isWr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(negedge refClk);
    psel = 1'b1;
    pwrite = isWr;
    paddr = a;
    pwdata = d;
    @(negedge refClk);
    penable = 1'b1;
    // Ready is looked at where it has settled, not at its launch edge
    do begin
      @(negedge refClk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    rd = prdata;
    `CHK(k, 1)
    `CHK(pslverr, 1'b0)
    @(negedge refClk);
    psel = 1'b0;
    penable = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic waitIdle(input logic lvl);
    int q;
    int k;
    q = 0;
    k = 0;
    while (q < 40 && k < 4000) begin
      @(negedge refClk);
      q = (sck === lvl) ? q + 1 : 0;
      k++;
    end
    `CHK(k < 4000, 1'b1)
  endtask

  task automatic sckHigh();
    int k;
    int n;
    k = 0;
    n = 0;
    while (sck !== 1'b1 && k < 500) begin
      @(negedge refClk);
      k++;
    end
    while (sck === 1'b1 && n < 100) begin
      @(negedge refClk);
      n++;
    end
    `CHK(n, HALF)
  endtask

  task automatic completeRun();
    if (failCount == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 4000 cycles; ceiling leaves ample slack
  always @(posedge refClk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      completeRun();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (12) @(negedge refClk);
    rstB = 1'b1;
    `CHK(slvSelB, 2'b11)
    `CHK(mosi, 1'b1)
    rdchk(CAP_OFS, FEAT);
    rdchk(MODE_OFS, 32'h0);
    wr(CAP_OFS, 32'hFFFF_FFFF);
    rdchk(CAP_OFS, FEAT);
    for (int a = 4; a <= 28; a += 4) begin
      wr(8'(a), 32'hFFFF_FFFF);
      rdchk(8'(a), 32'h0);
    end
    rdchk(8'h40, 32'h0);
    rdchk(SEL_OFS, 32'h3);
    wr(MASK_OFS, 32'h1234_5678);
    rdchk(MASK_OFS, 32'h1234_5678);
    wr(MODE_OFS, 32'hFCFF_FFFF);
    rdchk(MODE_OFS, 32'h7CFF_FFFE);
    wr(MODE_OFS, CFG);
    // Fill transmit queue while idle, then overfill
    for (int i = 0; i < 17; i++) begin
      apb(1'b0, EVENT_OFS, 32'h0);
      `CHK(rd[NOT_FULL_BIT], 1'b1)
      wr(TX_OFS, 32'(8'hA5 ^ 8'(i)));
    end
    apb(1'b0, EVENT_OFS, 32'h0);
    `CHK(rd[NOT_FULL_BIT], 1'b0)
    wr(TX_OFS, 32'hFF);
    wr(MODE_OFS, CFG | EN);
    sckHigh();
    waitIdle(1'b0);
    apb(1'b0, EVENT_OFS, 32'h0);
    `CHK(rd[NOT_EMPTY_BIT], 1'b1)
    `CHK(rd[OVERRUN_BIT], 1'b0)
    wr(TX_OFS, 32'h11);
    waitIdle(1'b0);
    apb(1'b0, EVENT_OFS, 32'h0);
    `CHK(rd[OVERRUN_BIT], 1'b1)
    for (int i = 0; i < 17; i++) begin
      rdchk(RX_OFS, 32'(8'hA5 ^ 8'(i)));
    end
    apb(1'b0, EVENT_OFS, 32'h0);
    `CHK(rd[NOT_EMPTY_BIT], 1'b0)
    wr(EVENT_OFS, 32'h1 << OVERRUN_BIT);
    apb(1'b0, EVENT_OFS, 32'h0);
    `CHK(rd[OVERRUN_BIT], 1'b0)
    wr(MODE_OFS, CFG);
    // Real link through the partner on select line 0
    wr(SEL_OFS, 32'h2);
    `CHK(slvSelB, 2'b10)
    wr(MODE_OFS, NOLOOP);
    wr(MODE_OFS, NOLOOP | EN);
    wr(TX_OFS, 32'h96);
    waitIdle(1'b0);
    `CHK(slvRx, 8'h96)
    rdchk(RX_OFS, 32'h3C);
    // Another master takes the bus
    @(negedge refClk);
    spiSelB = 1'b0;
    repeat (2) @(negedge refClk);
    spiSelB = 1'b1;
    apb(1'b0, EVENT_OFS, 32'h0);
    `CHK(rd[MULTI_MASTER_BIT], 1'b1)
    apb(1'b0, MODE_OFS, 32'h0);
    `CHK(rd[ENABLE_BIT], 1'b0)
    wr(EVENT_OFS, 32'h1 << MULTI_MASTER_BIT);
    apb(1'b0, EVENT_OFS, 32'h0);
    `CHK(rd[MULTI_MASTER_BIT], 1'b0)
    // Other clock phase and polarity, slow divide, hardware select
    wr(ASEL_OFS, 32'h1);
    rdchk(ASEL_OFS, 32'h1);
    wr(MODE_OFS, ALT);
    wr(TX_OFS, 32'hDEAD_BEEF);
    wr(MODE_OFS, ALT | EN);
    `CHK(slvSelB, 2'b01)
    waitIdle(1'b1);
    `CHK(slvSelB, 2'b10)
    rdchk(RX_OFS, 32'hDEAD_BEEF);
    completeRun();
  end
endmodule // tb
